// ---- aerv_regs.v ----
// Purpose: error reporting and virtual channel register bank on an APB slave
// Assumes: rst_n_i is the power-on / fundamental reset; error inputs are core-clock pulses
// Notes: zero-wait slave; unmapped addresses read zero and raise pslverr
//
// Function
// - uncorrectable status bits 0,4,12..20 sticky, write-one-clear, reset zero; rest zero
// - uncorrectable status register sits at 104h inside capability starting 100h
// - uncorrectable mask at 108h, sticky read/write, one bit per status bit, reset zero
// - uncorrectable severity at 10Ch sticky; bits 0,4,13,17,18 reset one
// - correctable status at 110h bits 0,6,7,8,12 sticky, write-one-clear, reset zero
// - correctable mask at 114h sticky read/write matching status bits, reset zero
// - first error pointer bits 4:0 at 118h, sticky read-only, reset zero
// - crc capable bits 5,7 read one; enables bits 6,8 sticky, reset zero
// - 16-byte header log 11Ch..128h, lowest byte of each word in bits 31:24
// - secondary status at 12Ch bits 0-3,5-13 sticky write-one-clear
// - secondary mask at 130h sticky; bits 3,5,7,8,9,10,12 reset one
// - secondary severity at 134h sticky; bits 6,8,9,12 reset one
// - secondary first error pointer bits 4:0 at 138h, reset zero, upper bits zero
// - secondary log bits 35:0 hold byte enables and data of attribute phase
// - log bits 39:36 first command, 43:40 dual-address command, 63:44 zero
// - log bits 95:64 first address, 127:96 second address, at 13Ch..148h
// - channel capability header at 150h: id 0002h, version 1h, next offset zero
// - zero extended channels, no arbitration; 154h..15Ch read zero
//
// Decided for this implementation: the APB interface to the registers.
`timescale 1ns/100ps
`include "aerv_defines.vh"

module aerv_regs #(
	parameter ADDR_W = `AERV_ADDR_W
) (
	input  wire              clk_i,
	input  wire              rst_n_i,
	input  wire              psel_i,
	input  wire              penable_i,
	input  wire              pwrite_i,
	input  wire [ADDR_W-1:0] paddr_i,
	input  wire [31:0]       pwdata_i,
	output wire              pready_o,
	output wire              pslverr_o,
	output reg  [31:0]       prdata_o,
	input  wire [31:0]       unc_err_i,
	input  wire [127:0]      unc_hdr_i,
	input  wire [31:0]       cor_err_i,
	input  wire [31:0]       sec_err_i,
	input  wire [35:0]       sec_attr_i,
	input  wire [3:0]        sec_cmd_lo_i,
	input  wire [3:0]        sec_cmd_hi_i,
	input  wire [31:0]       sec_addr_lo_i,
	input  wire [31:0]       sec_addr_hi_i,
	output wire              ecrc_gen_en_o,
	output wire              ecrc_chk_en_o,
	output reg               unc_fatal_o,
	output reg               unc_nonfatal_o,
	output reg               cor_report_o,
	output reg               sec_fatal_o,
	output reg               sec_nonfatal_o
);

	// status, mask, severity (all sticky, power-on reset only)
	reg  [31:0]  unc_stat_q;
	reg  [31:0]  unc_mask_q;
	reg  [31:0]  unc_sev_q;
	reg  [31:0]  cor_stat_q;
	reg  [31:0]  cor_mask_q;
	reg  [4:0]   fep_q;
	reg          ecrc_gen_en_q;
	reg          ecrc_chk_en_q;
	reg  [127:0] hlog_q;
	reg  [31:0]  sec_stat_q;
	reg  [31:0]  sec_mask_q;
	reg  [31:0]  sec_sev_q;
	reg  [4:0]   sec_fep_q;
	reg  [127:0] slog_q;

	wire         wr_en;
	wire         rd_setup;
	reg  [31:0]  rd_d;
	reg          hit_d;
	reg          hit_q;

	wire [31:0]  unc_ev;
	wire [31:0]  cor_ev;
	wire [31:0]  sec_ev;
	wire [31:0]  unc_live;
	wire [31:0]  sec_live;
	wire         unc_logged;
	wire         sec_logged;
	wire [31:0]  unc_clr;
	wire [31:0]  cor_clr;
	wire [31:0]  sec_clr;
	wire         unc_cap;
	wire         sec_cap;
	reg  [31:0]  unc_stat_d;
	reg  [31:0]  cor_stat_d;
	reg  [31:0]  sec_stat_d;
	reg  [31:0]  unc_mask_d;
	reg  [31:0]  unc_sev_d;
	reg  [31:0]  cor_mask_d;
	reg  [31:0]  sec_mask_d;
	reg  [31:0]  sec_sev_d;
	reg          ecrc_gen_en_d;
	reg          ecrc_chk_en_d;

	// one select per mapped word, except sel_vc_zero for the four zero channel words 154h..160h
	wire         sel_aer_hdr;
	wire         sel_unc_stat;
	wire         sel_unc_mask;
	wire         sel_unc_sev;
	wire         sel_cor_stat;
	wire         sel_cor_mask;
	wire         sel_cap_ctrl;
	wire         sel_hlog1;
	wire         sel_hlog2;
	wire         sel_hlog3;
	wire         sel_hlog4;
	wire         sel_sec_stat;
	wire         sel_sec_mask;
	wire         sel_sec_sev;
	wire         sel_sec_ctrl;
	wire         sel_slog1;
	wire         sel_slog2;
	wire         sel_slog3;
	wire         sel_slog4;
	wire         sel_rsvd;
	wire         sel_vc_hdr;
	wire         sel_vc_zero;

	// lowest set bit wins when several errors arrive together
	function [4:0] first_bit;
		input [31:0] v;
		integer i;
		begin
			first_bit = 5'h0_0;
			for (i = 31; i >= 0; i = i - 1) begin
				if (v[i]) begin
					first_bit = i[4:0];
				end
			end
		end
	endfunction

	assign wr_en    = psel_i & penable_i & pwrite_i;
	assign rd_setup = psel_i & ~penable_i & ~pwrite_i;
	assign pready_o = 1'b1;
	assign pslverr_o = psel_i & penable_i & ~hit_q;

	assign unc_ev = unc_err_i & `AERV_UNC_VALID;
	assign cor_ev = cor_err_i & `AERV_COR_VALID;
	assign sec_ev = sec_err_i & `AERV_SEC_VALID;

	assign unc_live = unc_ev & ~unc_mask_q;
	assign sec_live = sec_ev & ~sec_mask_q;

	// pointer is valid while the status bit it names is still set and not masked
	assign unc_logged = unc_stat_q[fep_q] & ~unc_mask_q[fep_q];
	assign sec_logged = sec_stat_q[sec_fep_q] & ~sec_mask_q[sec_fep_q];

	// word selects; anything not listed is unmapped and answers with an error
	assign sel_aer_hdr  = (paddr_i == `AERV_OFF_AER_HDR);
	assign sel_unc_stat = (paddr_i == `AERV_OFF_UNC_STAT);
	assign sel_unc_mask = (paddr_i == `AERV_OFF_UNC_MASK);
	assign sel_unc_sev  = (paddr_i == `AERV_OFF_UNC_SEV);
	assign sel_cor_stat = (paddr_i == `AERV_OFF_COR_STAT);
	assign sel_cor_mask = (paddr_i == `AERV_OFF_COR_MASK);
	assign sel_cap_ctrl = (paddr_i == `AERV_OFF_CAP_CTRL);
	assign sel_hlog1    = (paddr_i == `AERV_OFF_HLOG1);
	assign sel_hlog2    = (paddr_i == `AERV_OFF_HLOG2);
	assign sel_hlog3    = (paddr_i == `AERV_OFF_HLOG3);
	assign sel_hlog4    = (paddr_i == `AERV_OFF_HLOG4);
	assign sel_sec_stat = (paddr_i == `AERV_OFF_SEC_STAT);
	assign sel_sec_mask = (paddr_i == `AERV_OFF_SEC_MASK);
	assign sel_sec_sev  = (paddr_i == `AERV_OFF_SEC_SEV);
	assign sel_sec_ctrl = (paddr_i == `AERV_OFF_SEC_CTRL);
	assign sel_slog1    = (paddr_i == `AERV_OFF_SLOG1);
	assign sel_slog2    = (paddr_i == `AERV_OFF_SLOG2);
	assign sel_slog3    = (paddr_i == `AERV_OFF_SLOG3);
	assign sel_slog4    = (paddr_i == `AERV_OFF_SLOG4);
	assign sel_rsvd     = (paddr_i == `AERV_OFF_RSVD_14C);
	assign sel_vc_hdr   = (paddr_i == `AERV_OFF_VC_HDR);
	assign sel_vc_zero  = (paddr_i == `AERV_OFF_VC_CAP1) | (paddr_i == `AERV_OFF_VC_CAP2) |
		(paddr_i == `AERV_OFF_VC_CTRL) | (paddr_i == `AERV_OFF_VC0_RCAP);

	// capture only while no earlier unmasked error is logged
	assign unc_cap = (|unc_live) & ~unc_logged;
	assign sec_cap = (|sec_live) & ~sec_logged;

	// write-one-clear strobes
	assign unc_clr = (wr_en && sel_unc_stat) ? pwdata_i : 32'h0000_0000;
	assign cor_clr = (wr_en && sel_cor_stat) ? pwdata_i : 32'h0000_0000;
	assign sec_clr = (wr_en && sel_sec_stat) ? pwdata_i : 32'h0000_0000;

	assign ecrc_gen_en_o = ecrc_gen_en_q;
	assign ecrc_chk_en_o = ecrc_chk_en_q;

	// status next values: a new event beats a clear in the same cycle
	always @* begin
		unc_stat_d = ((unc_stat_q & ~unc_clr) | unc_ev) & `AERV_UNC_VALID;
		cor_stat_d = ((cor_stat_q & ~cor_clr) | cor_ev) & `AERV_COR_VALID;
		sec_stat_d = ((sec_stat_q & ~sec_clr) | sec_ev) & `AERV_SEC_VALID;
	end

	// sticky status flags, power-on reset only
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unc_stat_q <= 32'h0000_0000;
			cor_stat_q <= 32'h0000_0000;
			sec_stat_q <= 32'h0000_0000;
		end else begin
			unc_stat_q <= unc_stat_d;
			cor_stat_q <= cor_stat_d;
			sec_stat_q <= sec_stat_d;
		end
	end

	// software-written next values; other words leave them alone
	always @* begin
		unc_mask_d    = unc_mask_q;
		unc_sev_d     = unc_sev_q;
		cor_mask_d    = cor_mask_q;
		sec_mask_d    = sec_mask_q;
		sec_sev_d     = sec_sev_q;
		ecrc_gen_en_d = ecrc_gen_en_q;
		ecrc_chk_en_d = ecrc_chk_en_q;
		if (wr_en) begin
			if (sel_unc_mask) begin
				unc_mask_d = pwdata_i & `AERV_UNC_VALID;
			end else if (sel_unc_sev) begin
				unc_sev_d = pwdata_i & `AERV_UNC_VALID;
			end else if (sel_cor_mask) begin
				cor_mask_d = pwdata_i & `AERV_COR_VALID;
			end else if (sel_cap_ctrl) begin
				ecrc_gen_en_d = pwdata_i[`AERV_ECRC_GEN_EN_BIT];
				ecrc_chk_en_d = pwdata_i[`AERV_ECRC_CHK_EN_BIT];
			end else if (sel_sec_mask) begin
				sec_mask_d = pwdata_i & `AERV_SEC_VALID;
			end else if (sel_sec_sev) begin
				sec_sev_d = pwdata_i & `AERV_SEC_VALID;
			end
		end
	end

	// mask, severity and crc enable flops, power-on reset only
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unc_mask_q    <= `AERV_UNC_MASK_RST;
			unc_sev_q     <= `AERV_UNC_SEV_RST;
			cor_mask_q    <= `AERV_COR_MASK_RST;
			sec_mask_q    <= `AERV_SEC_MASK_RST;
			sec_sev_q     <= `AERV_SEC_SEV_RST;
			ecrc_gen_en_q <= 1'b0;
			ecrc_chk_en_q <= 1'b0;
		end else begin
			unc_mask_q    <= unc_mask_d;
			unc_sev_q     <= unc_sev_d;
			cor_mask_q    <= cor_mask_d;
			sec_mask_q    <= sec_mask_d;
			sec_sev_q     <= sec_sev_d;
			ecrc_gen_en_q <= ecrc_gen_en_d;
			ecrc_chk_en_q <= ecrc_chk_en_d;
		end
	end

	// express-side first error pointer and header log
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			fep_q  <= 5'h0_0;
			hlog_q <= 128'h0;
		end else if (unc_cap) begin
			fep_q  <= first_bit(unc_live);
			hlog_q <= unc_hdr_i;
		end
	end

	// secondary first error pointer and transaction log
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sec_fep_q <= 5'h0_0;
			slog_q    <= 128'h0;
		end else if (sec_cap) begin
			sec_fep_q     <= first_bit(sec_live);
			slog_q[35:0]  <= sec_attr_i;
			slog_q[39:36] <= sec_cmd_lo_i;
			slog_q[43:40] <= sec_cmd_hi_i;
			slog_q[63:44] <= 20'h0_0000;
			slog_q[95:64] <= sec_addr_lo_i;
			slog_q[127:96] <= sec_addr_hi_i;
		end
	end

	// error message requests, one cycle after the unmasked event
	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			unc_fatal_o    <= 1'b0;
			unc_nonfatal_o <= 1'b0;
			cor_report_o   <= 1'b0;
			sec_fatal_o    <= 1'b0;
			sec_nonfatal_o <= 1'b0;
		end else begin
			unc_fatal_o    <= |(unc_live & unc_sev_q);
			unc_nonfatal_o <= |(unc_live & ~unc_sev_q);
			cor_report_o   <= |(cor_ev & ~cor_mask_q);
			sec_fatal_o    <= |(sec_live & sec_sev_q);
			sec_nonfatal_o <= |(sec_live & ~sec_sev_q);
		end
	end

	// read mux, decoded in the setup phase
	always @* begin
		rd_d  = 32'h0000_0000;
		hit_d = 1'b1;
		if (sel_aer_hdr) begin
			rd_d = `AERV_AER_HDR_VAL;
		end else if (sel_unc_stat) begin
			rd_d = unc_stat_q;
		end else if (sel_unc_mask) begin
			rd_d = unc_mask_q;
		end else if (sel_unc_sev) begin
			rd_d = unc_sev_q;
		end else if (sel_cor_stat) begin
			rd_d = cor_stat_q;
		end else if (sel_cor_mask) begin
			rd_d = cor_mask_q;
		end else if (sel_cap_ctrl) begin
			rd_d[`AERV_FEP_MSB:0]          = fep_q;
			rd_d[`AERV_ECRC_GEN_CAP_BIT]   = 1'b1;
			rd_d[`AERV_ECRC_GEN_EN_BIT]    = ecrc_gen_en_q;
			rd_d[`AERV_ECRC_CHK_CAP_BIT]   = 1'b1;
			rd_d[`AERV_ECRC_CHK_EN_BIT]    = ecrc_chk_en_q;
		end else if (sel_hlog1) begin
			rd_d = hlog_q[127:96];
		end else if (sel_hlog2) begin
			rd_d = hlog_q[95:64];
		end else if (sel_hlog3) begin
			rd_d = hlog_q[63:32];
		end else if (sel_hlog4) begin
			rd_d = hlog_q[31:0];
		end else if (sel_sec_stat) begin
			rd_d = sec_stat_q;
		end else if (sel_sec_mask) begin
			rd_d = sec_mask_q;
		end else if (sel_sec_sev) begin
			rd_d = sec_sev_q;
		end else if (sel_sec_ctrl) begin
			rd_d[4:0] = sec_fep_q;
		end else if (sel_slog1) begin
			rd_d = slog_q[31:0];
		end else if (sel_slog2) begin
			rd_d = slog_q[63:32];
		end else if (sel_slog3) begin
			rd_d = slog_q[95:64];
		end else if (sel_slog4) begin
			rd_d = slog_q[127:96];
		end else if (sel_rsvd) begin
			rd_d = 32'h0000_0000;
		end else if (sel_vc_hdr) begin
			rd_d = `AERV_VC_HDR_VAL;
		end else if (sel_vc_zero) begin
			rd_d = 32'h0000_0000;
		end else begin
			hit_d = 1'b0;
		end
	end

	always @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prdata_o <= 32'h0000_0000;
			hit_q    <= 1'b0;
		end else if (psel_i && !penable_i) begin
			prdata_o <= rd_setup ? rd_d : 32'h0000_0000;
			hit_q    <= hit_d;
		end
	end

endmodule // aerv_regs

// ---- aerv_defines.vh ----
// Purpose: offsets, field masks and reset values of the error and channel register bank
// Assumes: byte addresses inside configuration space, one 32-bit word per register
// Notes: definitions only
`ifndef AERV_DEFINES_VH
`define AERV_DEFINES_VH

`define AERV_ADDR_W            12

`define AERV_OFF_AER_HDR       12'h100
`define AERV_OFF_UNC_STAT      12'h104
`define AERV_OFF_UNC_MASK      12'h108
`define AERV_OFF_UNC_SEV       12'h10C
`define AERV_OFF_COR_STAT      12'h110
`define AERV_OFF_COR_MASK      12'h114
`define AERV_OFF_CAP_CTRL      12'h118
`define AERV_OFF_HLOG1         12'h11C
`define AERV_OFF_HLOG2         12'h120
`define AERV_OFF_HLOG3         12'h124
`define AERV_OFF_HLOG4         12'h128
`define AERV_OFF_SEC_STAT      12'h12C
`define AERV_OFF_SEC_MASK      12'h130
`define AERV_OFF_SEC_SEV       12'h134
`define AERV_OFF_SEC_CTRL      12'h138
`define AERV_OFF_SLOG1         12'h13C
`define AERV_OFF_SLOG2         12'h140
`define AERV_OFF_SLOG3         12'h144
`define AERV_OFF_SLOG4         12'h148
`define AERV_OFF_RSVD_14C      12'h14C
`define AERV_OFF_VC_HDR        12'h150
`define AERV_OFF_VC_CAP1       12'h154
`define AERV_OFF_VC_CAP2       12'h158
`define AERV_OFF_VC_CTRL       12'h15C
`define AERV_OFF_VC0_RCAP      12'h160

// implemented bits
`define AERV_UNC_VALID         32'h001F_F011
`define AERV_COR_VALID         32'h0000_11C1
`define AERV_SEC_VALID         32'h0000_3FEF

// reset values
`define AERV_UNC_MASK_RST      32'h0000_0000
`define AERV_UNC_SEV_RST       32'h0006_2011
`define AERV_COR_MASK_RST      32'h0000_0000
`define AERV_SEC_MASK_RST      32'h0000_17A8
`define AERV_SEC_SEV_RST       32'h0000_1340

// capability headers: id, version, next offset
`define AERV_AER_HDR_VAL       32'h1501_0001
`define AERV_VC_HDR_VAL        32'h0001_0002

// caps and control fields
`define AERV_FEP_MSB           4
`define AERV_ECRC_GEN_CAP_BIT  5
`define AERV_ECRC_GEN_EN_BIT   6
`define AERV_ECRC_CHK_CAP_BIT  7
`define AERV_ECRC_CHK_EN_BIT   8

`endif

// ---- aerv_regs_chk.sv ----
// Purpose: port checks of the error and channel register bank
// Assumes: zero-wait slave, read data valid in access phase
// Notes: bound into aerv_regs
`timescale 1ns/100ps
`include "aerv_defines.vh"
module aerv_regs_chk (
	input logic        clk_i,
	input logic        rst_n_i,
	input logic        psel_i,
	input logic        penable_i,
	input logic        pwrite_i,
	input logic [11:0] paddr_i,
	input logic [31:0] pwdata_i,
	input logic        pslverr_o,
	input logic [31:0] prdata_o,
	input logic [31:0] unc_err_i,
	input logic        ecrc_gen_en_o,
	input logic        ecrc_chk_en_o,
	input logic        unc_fatal_o,
	input logic        unc_nonfatal_o
);
	wire rd_acc = psel_i & penable_i & ~pwrite_i;
	wire wr_acc = psel_i & penable_i & pwrite_i;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	property p_unc_zero; rd_acc && paddr_i == 12'h104 |->
		!pslverr_o && (prdata_o & ~`AERV_UNC_VALID) == 32'h0; endproperty
	a_unc_zero: assert property (p_unc_zero) else $error("unc status spare bits");
	property p_cor_zero; rd_acc && paddr_i == 12'h110 |->
		!pslverr_o && (prdata_o & ~`AERV_COR_VALID) == 32'h0; endproperty
	a_cor_zero: assert property (p_cor_zero) else $error("cor status spare bits");
	property p_fep_top; rd_acc && paddr_i == 12'h138 |-> prdata_o[31:5] == 27'h0;
	endproperty
	a_fep_top: assert property (p_fep_top) else $error("pointer upper bits set");
	property p_caps; rd_acc && paddr_i == 12'h118 |->
		prdata_o[5] && prdata_o[7] && prdata_o[31:9] == 23'h0; endproperty
	a_caps: assert property (p_caps) else $error("crc capable bits wrong");
	property p_vc_hdr; rd_acc && paddr_i == 12'h150 |-> prdata_o == `AERV_VC_HDR_VAL;
	endproperty
	a_vc_hdr: assert property (p_vc_hdr) else $error("channel header wrong");
	property p_vc_zero; rd_acc && paddr_i inside {[12'h154:12'h15C]} |-> prdata_o == 32'h0;
	endproperty
	a_vc_zero: assert property (p_vc_zero) else $error("channel caps not zero");
	property p_ecrc; $changed({ecrc_chk_en_o, ecrc_gen_en_o}) |-> $past(wr_acc)
		&& $past(paddr_i) == 12'h118 && $past({pwdata_i[8], pwdata_i[6]}) ==
		{ecrc_chk_en_o, ecrc_gen_en_o}; endproperty
	a_ecrc: assert property (p_ecrc) else $error("crc enable moved alone");
	property p_unc_msg; unc_fatal_o || unc_nonfatal_o |->
		$past(|(unc_err_i & `AERV_UNC_VALID)); endproperty
	a_unc_msg: assert property (p_unc_msg) else $error("message without event");
endmodule // aerv_regs_chk
bind aerv_regs aerv_regs_chk u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i),
	.penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
	.pslverr_o(pslverr_o), .prdata_o(prdata_o), .unc_err_i(unc_err_i),
	.ecrc_gen_en_o(ecrc_gen_en_o), .ecrc_chk_en_o(ecrc_chk_en_o),
	.unc_fatal_o(unc_fatal_o), .unc_nonfatal_o(unc_nonfatal_o));

// ---- tb_aerv_regs.sv ----
// Purpose: self-checking bench of the error and channel register bank
// Assumes: zero-wait apb slave, error inputs taken each rising edge
// Notes: reset table first, then event, clear and access cases
`timescale 1ns/100ps
module tb_aerv_regs;
	logic         clk_i = 0, rst_n_i = 0, psel_i = 0, penable_i = 0, pwrite_i = 0;
	logic [11:0]  paddr_i = 12'h0;
	logic [31:0]  pwdata_i = 32'h0, prdata_o, q, unc_err_i = 0, cor_err_i = 0, sec_err_i = 0;
	logic [127:0] unc_hdr_i = 128'h0011_2233_4455_6677_8899_AABB_CCDD_EEFF;
	logic [35:0]  sec_attr_i = 36'h9_1234_5678;
	logic [3:0]   sec_cmd_lo_i = 4'h6, sec_cmd_hi_i = 4'hD;
	logic [31:0]  sec_addr_lo_i = 32'hAAAA_0001, sec_addr_hi_i = 32'h5555_0002;
	logic         pready_o, pslverr_o, e, ecrc_gen_en_o, ecrc_chk_en_o;
	logic         unc_fatal_o, unc_nonfatal_o, cor_report_o, sec_fatal_o, sec_nonfatal_o;
	int           errors = 0, compares = 0, i;
	logic [11:0]  ta [16] = '{12'h104, 12'h108, 12'h10C, 12'h110, 12'h114, 12'h118, 12'h11C,
		12'h12C, 12'h130, 12'h134, 12'h138, 12'h13C, 12'h150, 12'h154, 12'h158, 12'h15C};
	logic [31:0]  tv [16] = '{0, 0, 32'h0006_2011, 0, 0, 32'h0000_00A0, 0, 0,
		32'h0000_17A8, 32'h0000_1340, 0, 0, 32'h0001_0002, 0, 0, 0};
	logic [11:0]  ma [4] = '{12'h108, 12'h114, 12'h130, 12'h134};
	logic [31:0]  mv [4] = '{32'h001F_F011, 32'h0000_11C1, 32'h0000_3FEF, 32'h0000_3FEF};
	aerv_regs u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
		.pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .pready_o(pready_o),
		.pslverr_o(pslverr_o), .prdata_o(prdata_o), .unc_err_i(unc_err_i),
		.unc_hdr_i(unc_hdr_i), .cor_err_i(cor_err_i), .sec_err_i(sec_err_i),
		.sec_attr_i(sec_attr_i), .sec_cmd_lo_i(sec_cmd_lo_i), .sec_cmd_hi_i(sec_cmd_hi_i),
		.sec_addr_lo_i(sec_addr_lo_i), .sec_addr_hi_i(sec_addr_hi_i),
		.ecrc_gen_en_o(ecrc_gen_en_o), .ecrc_chk_en_o(ecrc_chk_en_o),
		.unc_fatal_o(unc_fatal_o), .unc_nonfatal_o(unc_nonfatal_o),
		.cor_report_o(cor_report_o), .sec_fatal_o(sec_fatal_o),
		.sec_nonfatal_o(sec_nonfatal_o));
	initial forever #2 clk_i = ~clk_i;
	task automatic give_verdict;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			errors++;
			$display("BAD %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel_i <= 1'b1;
		pwrite_i <= w;
		paddr_i <= a;
		pwdata_i <= d;
		@(posedge clk_i);
		penable_i <= 1'b1;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (pready_o !== 1'b1 && n < 16);
		if (n >= 16) begin
			errors++;
			give_verdict;
		end
		q = prdata_o;
		e = pslverr_o;
		psel_i <= 1'b0;
		penable_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(q, x);
	endtask
	// one-cycle error event, then the message pulses in the following cycle
	task automatic ev(input logic [95:0] v, input logic [4:0] x);
		{unc_err_i, cor_err_i, sec_err_i} <= v;
		@(posedge clk_i);
		{unc_err_i, cor_err_i, sec_err_i} <= 96'h0;
		@(negedge clk_i);
		chk({27'h0, unc_fatal_o, unc_nonfatal_o, cor_report_o, sec_fatal_o, sec_nonfatal_o},
			{27'h0, x});
		@(posedge clk_i);
	endtask
	initial begin
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		for (i = 0; i < 16; i++)
			rd(ta[i], tv[i]);
		$display("test reset values done");
		ev({64'h0, 32'h0000_0040}, 5'b00010);
		rd(12'h12C, 32'h0000_0040);
		rd(12'h138, 32'h0000_0006);
		rd(12'h13C, 32'h1234_5678);
		rd(12'h140, 32'h0000_0D69);
		rd(12'h144, 32'hAAAA_0001);
		rd(12'h148, 32'h5555_0002);
		apb(1'b1, 12'h12C, 32'h0);
		rd(12'h12C, 32'h0000_0040);
		apb(1'b1, 12'h12C, 32'h0000_0040);
		rd(12'h12C, 32'h0);
		$display("test secondary log done");
		ev({32'h0000_1000, 64'h0}, 5'b01000);
		rd(12'h104, 32'h0000_1000);
		rd(12'h118, 32'h0000_00AC);
		rd(12'h11C, 32'h0011_2233);
		apb(1'b1, 12'h11C, 32'hFFFF_FFFF);
		rd(12'h11C, 32'h0011_2233);
		rd(12'h128, 32'hCCDD_EEFF);
		apb(1'b1, 12'h104, 32'hFFFF_FFFF);
		rd(12'h104, 32'h0);
		ev({32'h0, 32'hFFFF_FFFF, 32'h0}, 5'b00100);
		apb(1'b1, 12'h110, 32'h0000_0100);
		rd(12'h110, 32'h0000_10C1);
		$display("test status clear done");
		for (i = 0; i < 4; i++) begin
			apb(1'b1, ma[i], 32'hFFFF_FFFF);
			rd(ma[i], mv[i]);
		end
		ev({32'h0000_0010, 64'h0}, 5'b00000);
		rd(12'h104, 32'h0000_0010);
		rd(12'h118, 32'h0000_00AC);
		apb(1'b1, 12'h118, 32'hFFFF_FFFF);
		rd(12'h118, 32'h0000_01EC);
		chk({30'h0, ecrc_gen_en_o, ecrc_chk_en_o}, 32'h3);
		apb(1'b1, 12'h150, 32'hFFFF_FFFF);
		rd(12'h150, 32'h0001_0002);
		rd(12'h14C, 32'h0);
		chk({31'h0, e}, 32'h0);
		rd(12'h164, 32'h0);
		chk({31'h0, e}, 32'h1);
		rd(12'h100, 32'h1501_0001);
		chk({31'h0, e}, 32'h0);
		$display("test masks and access done");
		rst_n_i <= 1'b0;
		repeat (5) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		rd(12'h130, 32'h0000_17A8);
		rd(12'h118, 32'h0000_00A0);
		ev({32'h0000_0001, 32'h0, 32'h0000_0001}, 5'b10001);
		rd(12'h12C, 32'h0000_0001);
		rd(12'h104, 32'h0000_0001);
		$display("test second reset done");
		give_verdict;
	end
endmodule // tb_aerv_regs
